// *** hw/devctl_consts.svh ***
// Register offsets, field positions, reset values and timing counts of the device control block.
`ifndef DEVCTL_CONSTS_SVH
`define DEVCTL_CONSTS_SVH

// Register byte offsets.
`define OFS_CONTROL      12'h000
`define OFS_STATUS       12'h004
`define OFS_TEMP_SEL     12'h008
`define OFS_TEMP_READ    12'h00C
`define OFS_COOL_MODE    12'h010
`define OFS_SETPOINT     12'h014
`define OFS_NAMING_VER   12'h018
`define OFS_SCAN_TYPE    12'h01C
`define OFS_VENDOR       12'h020
`define OFS_MODEL        12'h024
`define OFS_SERIAL       12'h028
`define OFS_FW_VER       12'h02C
`define OFS_LOCKED_PARAM 12'h030
`define OFS_USER_LABEL   12'h040
`define OFS_LABEL_END    12'h04F

// Control register bits (write-only command bits).
`define CTL_FULL_RESET   0
`define CTL_HEAD_RESET   1
`define CTL_ACQ_START    2
`define CTL_ACQ_STOP     3
`define CTL_SETTINGS_LD  4

// Status register bits.
`define STS_READY        0
`define STS_ACQ_ON       1
`define STS_FAN_ON       2
`define STS_OVERRIDE     3
`define STS_HEAD_RST     4
`define STS_REFUSED      5
`define STS_SPACE_LSB    8

// Reset values.
`define RST_COOL_MODE    2'h2
`define RST_SETPOINT     8'h32
`define RST_TEMP_SEL     2'h0

// Thermal constants, degrees Celsius.
`define OVERTEMP_C       8'h50
`define HYST_C           8'h04

// Naming convention version and scan type.
`define NAMING_MAJOR     8'h02
`define NAMING_MINOR     8'h03
`define NAMING_SUBMINOR  8'h00
`define SCAN_AREA        32'h0000_0000

// Head reset pulse length in cycles.
`define HEAD_RST_CYCLES  4'h8

`endif

// *** hw/devctl_pkg.sv ***
// Types shared by the device control block.
package devctl_pkg;

   typedef enum logic [2:0] {
      ST_FW_CHECK  = 3'b000,
      ST_FW_LOAD   = 3'b001,
      ST_SRC_READ  = 3'b010,
      ST_CFG_LOAD  = 3'b011,
      ST_READY     = 3'b100
   } boot_state_e;

   typedef enum logic [1:0] {
      COOL_OFF  = 2'b00,
      COOL_ON   = 2'b01,
      COOL_AUTO = 2'b10
   } cool_mode_e;

   typedef struct packed {
      boot_state_e  boot;
      logic [2:0]   space;
      logic         acq_on;
      logic [1:0]   temp_sel;
      logic [1:0]   cool_mode;
      logic [7:0]   setpoint;
      logic         auto_fan;
      logic         override;
      logic         fan_on;
      logic         refused;
      logic [31:0]  locked_param;
      logic [3:0]   head_cnt;
      logic         head_rst_n;
      logic         link_rst_n;
      logic         soft_reset;
      logic         fw_req;
      logic         cfg_req;
      logic         settings_ld;
      logic         pready;
      logic         pslverr;
      logic [31:0]  prdata;
      logic [127:0] label;
   } devctl_s;

endpackage

// *** hw/devctl.sv ***
// Device control and fan controller of the camera, reached over APB.
`include "devctl_consts.svh"

module devctl #(
   parameter logic [31:0] VENDOR_ID = 32'h0000_0001,   // Arbitrary value.
   parameter logic [31:0] MODEL_ID  = 32'h0000_0002,   // Arbitrary value.
   parameter logic [31:0] SERIAL_ID = 32'h0000_0003,   // Arbitrary value.
   parameter logic [31:0] FW_ID     = 32'h0000_0004    // Arbitrary value.
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   input  wire logic        fw_valid,
   input  wire logic        fw_done,
   input  wire logic [2:0]  boot_source,
   input  wire logic        cfg_done,
   output logic             fw_load_req,
   output logic             cfg_load_req,
   output logic [2:0]       cfg_space,
   output logic             link_rst_n,
   output logic             head_rst_n,
   output logic             settings_load,
   output logic             acq_active,
   output logic             fan_on,
   input  wire logic [7:0]  temp_sensor,
   input  wire logic [7:0]  temp_mainboard,
   input  wire logic [7:0]  temp_sensorboard,
   input  wire logic [7:0]  temp_logic
);

   // ************************************************************
   // Input synchronisers
   // ************************************************************

   logic [2:0]         src_a, src_b;
   logic [31:0]        status_word;
   logic               fwd_sync, cfgd_sync, fwv_sync;
   logic [2:0]         sync_a, sync_b;
   devctl_pkg::devctl_s st_reg, st_next;
   logic [7:0]         temp_sel_val;
   logic [7:0]         temp_max;
   logic               wr_acc, rd_acc;

   // Flash handshake lines come from a slower loader domain, so two flops each.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {fw_valid, fw_done, cfg_done};
         sync_b <= sync_a;
      end
   end
   assign fwv_sync  = sync_b[2];
   assign fwd_sync  = sync_b[1];
   assign cfgd_sync = sync_b[0];

   // The startup record comes from the flash side as well, so it passes two flops too.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_a <= 3'h0;
         src_b <= 3'h0;
      end else begin
         src_a <= boot_source;
         src_b <= src_a;
      end
   end

   // ************************************************************
   // Temperature selection
   // ************************************************************

   // Probes are whole degrees from this clock domain and need no flops.
   // Reading follows the location selector; the fan looks at the hottest point.
   always_comb begin
      unique case (st_reg.temp_sel)
         2'd0: temp_sel_val = temp_sensor;
         2'd1: temp_sel_val = temp_mainboard;
         2'd2: temp_sel_val = temp_sensorboard;
         2'd3: temp_sel_val = temp_logic;
      endcase
   end

   // Internal temperature is taken as the highest of the four probes.
   always_comb begin
      temp_max = temp_sensor;
      if (temp_mainboard > temp_max) temp_max = temp_mainboard;
      if (temp_sensorboard > temp_max) temp_max = temp_sensorboard;
      if (temp_logic > temp_max) temp_max = temp_logic;
   end

   // ************************************************************
   // Bus decode
   // ************************************************************

   // An access is taken at the first rising edge of its access phase; pready rises
   // at that same edge together with prdata and pslverr and stands for one cycle.
   // Masking with the registered pready stops an access phase that is still held
   // while the master looks at the answer from being taken a second time.
   // Reads are served at any time, writes only once startup has finished.
   assign wr_acc = psel && penable && pwrite && !st_reg.pready;
   assign rd_acc = psel && penable && !pwrite && !st_reg.pready;

   // Status word; the workspace field reads back the code that was loaded.
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`STS_READY] = (st_reg.boot == devctl_pkg::ST_READY);
      status_word[`STS_ACQ_ON] = st_reg.acq_on;
      status_word[`STS_FAN_ON] = st_reg.fan_on;
      status_word[`STS_OVERRIDE] = st_reg.override;
      status_word[`STS_HEAD_RST] = ~st_reg.head_rst_n;
      status_word[`STS_REFUSED] = st_reg.refused;
      status_word[`STS_SPACE_LSB +: 3] = st_reg.space;
   end

   // ************************************************************
   // Next-state logic
   // ************************************************************

   // All of st_reg advances here, the synchroniser flops apart; reset actions share one path.
   always_comb begin
      st_next = st_reg;
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.fw_req  = 1'b0;
      st_next.settings_ld = 1'b0;
      st_next.link_rst_n  = 1'b1;

      // Boot sequence: firmware check, load, source read, workspace load.
      // Both flash requests are levels that stay up until the loader reports done.
      // A rerun after full reset starts here again with every request low.
      // Only writes wait for the ready state; reads are answered throughout.
      unique case (st_reg.boot)
         devctl_pkg::ST_FW_CHECK: begin
            if (fwv_sync) begin
               st_next.boot   = devctl_pkg::ST_FW_LOAD;
               st_next.fw_req = 1'b1;
            end
         end
         devctl_pkg::ST_FW_LOAD: begin
            st_next.fw_req = 1'b1;
            if (fwd_sync) begin
               st_next.fw_req = 1'b0;
               st_next.boot   = devctl_pkg::ST_SRC_READ;
            end
         end
         devctl_pkg::ST_SRC_READ: begin
            // Codes above four fall back to the factory space.
            st_next.space   = (src_b > 3'd4) ? 3'd0 : src_b;
            st_next.cfg_req = 1'b1;
            st_next.boot    = devctl_pkg::ST_CFG_LOAD;
         end
         devctl_pkg::ST_CFG_LOAD: begin
            if (cfgd_sync) begin
               st_next.cfg_req = 1'b0;
               st_next.boot    = devctl_pkg::ST_READY;
            end
         end
         devctl_pkg::ST_READY: begin
         end
         default: st_next.boot = devctl_pkg::ST_FW_CHECK;
      endcase

      // Head reset pulse counts down while the link keeps running.
      // The count also runs after power-up, so the head leaves reset some cycles
      // after the block does; the link engine never waits on it.
      if (st_reg.head_cnt != 4'h0) begin
         st_next.head_cnt   = st_reg.head_cnt - 4'h1;
         st_next.head_rst_n = 1'b0;
      end else begin
         st_next.head_rst_n = 1'b1;
      end

      // Fan control: override above threshold, then mode.
      // Override and automatic decision both use the hottest probe, so one cool
      // probe cannot hide a hot one. Inside the band from the setpoint down to
      // 4 C below it the automatic decision keeps its last value, which stops
      // the fan from chattering while the temperature hovers at the setpoint.
      // Limitation: a setpoint below 4 C never lets automatic mode switch off.
      // The override is applied last, so it wins over every cooling mode.
      st_next.override = (temp_max > `OVERTEMP_C);
      if (temp_max >= st_reg.setpoint) begin
         st_next.auto_fan = 1'b1;
      end else if ({1'b0, temp_max} + {1'b0, `HYST_C} <= {1'b0, st_reg.setpoint}) begin
         st_next.auto_fan = 1'b0;
      end
      unique case (st_reg.cool_mode)
         devctl_pkg::COOL_ON:   st_next.fan_on = 1'b1;
         devctl_pkg::COOL_AUTO: st_next.fan_on = st_next.auto_fan;
         default:               st_next.fan_on = 1'b0;
      endcase
      if (st_next.override) st_next.fan_on = 1'b1;

      // APB read data; answer comes one cycle after the access phase opens.
      if (rd_acc) begin
         st_next.pready = 1'b1;
         st_next.prdata = 32'h0000_0000;
         case (paddr)
            `OFS_STATUS:       st_next.prdata = status_word;
            `OFS_TEMP_SEL:     st_next.prdata = {30'h0, st_reg.temp_sel};
            `OFS_TEMP_READ:    st_next.prdata = {24'h0, temp_sel_val};
            `OFS_COOL_MODE:    st_next.prdata = {30'h0, st_reg.cool_mode};
            `OFS_SETPOINT:     st_next.prdata = {24'h0, st_reg.setpoint};
            `OFS_NAMING_VER:   st_next.prdata = {8'h0, `NAMING_MAJOR, `NAMING_MINOR,
                                                 `NAMING_SUBMINOR};
            `OFS_SCAN_TYPE:    st_next.prdata = `SCAN_AREA;
            `OFS_VENDOR:       st_next.prdata = VENDOR_ID;
            `OFS_MODEL:        st_next.prdata = MODEL_ID;
            `OFS_SERIAL:       st_next.prdata = SERIAL_ID;
            `OFS_FW_VER:       st_next.prdata = FW_ID;
            `OFS_LOCKED_PARAM: st_next.prdata = st_reg.locked_param;
            `OFS_CONTROL:      st_next.prdata = 32'h0000_0000;
            default: begin
               if (paddr >= `OFS_USER_LABEL && paddr <= `OFS_LABEL_END)
                  st_next.prdata = st_reg.label[paddr[3:2]*32 +: 32];
               else
                  st_next.pslverr = 1'b1;
            end
         endcase
         if (paddr[1:0] != 2'b00) st_next.pslverr = 1'b1;
      end

      // APB writes; refused with an error until startup has finished.
      // Command bits act in the order start, stop, load, head reset, full reset,
      // so a write that sets both start and stop leaves acquisition off.
      if (wr_acc) begin
         st_next.pready = 1'b1;
         if (st_reg.boot != devctl_pkg::ST_READY || paddr[1:0] != 2'b00) begin
            st_next.pslverr = 1'b1;
         end else begin
            case (paddr)
               `OFS_CONTROL: begin
                  if (pwdata[`CTL_ACQ_START]) st_next.acq_on = 1'b1;
                  if (pwdata[`CTL_ACQ_STOP])  st_next.acq_on = 1'b0;
                  if (pwdata[`CTL_SETTINGS_LD]) st_next.settings_ld = 1'b1;
                  if (pwdata[`CTL_HEAD_RESET]) begin
                     st_next.head_cnt = `HEAD_RST_CYCLES;
                     st_next.acq_on   = 1'b0;
                  end
                  if (pwdata[`CTL_FULL_RESET]) st_next.soft_reset = 1'b1;
               end
               `OFS_TEMP_SEL:  st_next.temp_sel  = pwdata[1:0];
               `OFS_COOL_MODE: begin
                  if (pwdata[1:0] != 2'b11) st_next.cool_mode = pwdata[1:0];
                  else st_next.pslverr = 1'b1;
               end
               `OFS_SETPOINT:  st_next.setpoint  = pwdata[7:0];
               `OFS_LOCKED_PARAM: begin
                  // The refused flag follows the latest write here; a good write clears it.
                  st_next.refused = st_reg.acq_on;
                  if (st_reg.acq_on) st_next.pslverr = 1'b1;
                  else st_next.locked_param = pwdata;
               end
               default: begin
                  if (paddr >= `OFS_USER_LABEL && paddr <= `OFS_LABEL_END)
                     st_next.label[paddr[3:2]*32 +: 32] = pwdata;
                  else
                     st_next.pslverr = 1'b1;
               end
            endcase
         end
      end

      // Full reset: pulse the link engine reset and rerun startup from the top.
      // The command write is answered first and the reset lands on the next edge,
      // so the host gets a clean answer before the link engine restarts.
      // The fan keeps its state across the restart so that a hot camera is not
      // left uncooled; the override is recomputed from the probes one edge later.
      if (st_reg.soft_reset && st_reg.pready) begin
         st_next = '0;
         st_next.boot       = devctl_pkg::ST_FW_CHECK;
         st_next.cool_mode  = `RST_COOL_MODE;
         st_next.setpoint   = `RST_SETPOINT;
         st_next.temp_sel   = `RST_TEMP_SEL;
         st_next.head_cnt   = `HEAD_RST_CYCLES;
         st_next.head_rst_n = 1'b0;
         st_next.link_rst_n = 1'b0;
         st_next.override   = st_reg.override;
         st_next.fan_on     = st_reg.fan_on;
      end
   end

   // ************************************************************
   // State register
   // ************************************************************

   // Reset takes constants only; the head is held in reset until its count ends.
   // The fan starts off; the first edge after reset recomputes it from the probes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg            <= '0;
         st_reg.boot       <= devctl_pkg::ST_FW_CHECK;
         st_reg.cool_mode  <= `RST_COOL_MODE;
         st_reg.setpoint   <= `RST_SETPOINT;
         st_reg.temp_sel   <= `RST_TEMP_SEL;
         st_reg.link_rst_n <= 1'b1;
         st_reg.head_rst_n <= 1'b0;
         st_reg.head_cnt   <= `HEAD_RST_CYCLES;
      end else begin
         st_reg <= st_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   // Every output is a field of the state register.
   // Driving them straight from flops keeps combinational glitches off the pins.
   assign pready        = st_reg.pready;
   assign pslverr       = st_reg.pslverr;
   assign prdata        = st_reg.prdata;
   assign fw_load_req   = st_reg.fw_req;
   assign cfg_load_req  = st_reg.cfg_req;
   assign cfg_space     = st_reg.space;
   assign link_rst_n    = st_reg.link_rst_n;
   assign head_rst_n    = st_reg.head_rst_n;
   assign settings_load = st_reg.settings_ld;
   assign acq_active    = st_reg.acq_on;
   assign fan_on        = st_reg.fan_on;

endmodule

// *** tb/devctl_monitor.sv ***
// Concurrent checks on the ports of the device control block.
`include "devctl_consts.svh"
module devctl_monitor (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       fw_load_req,
   input wire logic       cfg_load_req,
   input wire logic [2:0] cfg_space,
   input wire logic [2:0] boot_source,
   input wire logic       link_rst_n,
   input wire logic       head_rst_n,
   input wire logic       acq_active,
   input wire logic       fan_on,
   input wire logic [7:0] temp_sensor,
   input wire logic [7:0] temp_mainboard,
   input wire logic [7:0] temp_sensorboard,
   input wire logic [7:0] temp_logic
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] hot;

   // The override follows the hottest probe, so one cool probe cannot hide a hot one.
   always_comb begin
      hot = temp_sensor;
      if (temp_mainboard > hot) hot = temp_mainboard;
      if (temp_sensorboard > hot) hot = temp_sensorboard;
      if (temp_logic > hot) hot = temp_logic;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Bus answers and refusals.
   a_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing one cycle after access phase");
   a_err_answer: assert property (pslverr |-> pready && $past(psel && penable))
      else $error("pslverr outside an answer");
   // Resets and startup order.
   a_link_pulse: assert property (!link_rst_n |=> link_rst_n)
      else $error("link reset longer than one cycle");
   a_head_hold: assert property ($fell(head_rst_n) |-> (!head_rst_n) [*8])
      else $error("head reset shorter than eight cycles");
   a_head_acq: assert property ($fell(head_rst_n) |-> ##[0:2] !acq_active)
      else $error("acquisition kept running through head reset");
   a_fw_first: assert property (fw_load_req |-> !cfg_load_req)
      else $error("workspace load during firmware load");
   a_space_pick: assert property ($rose(cfg_load_req) |-> ##[0:1]
      (cfg_space == ((boot_source > 3'h4) ? 3'h0 : boot_source)))
      else $error("workspace space differs from startup source");
   // Thermal override.
   a_hot_fan: assert property (hot > `OVERTEMP_C |=> fan_on)
      else $error("fan off while over temperature");
endmodule

bind devctl devctl_monitor u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .fw_load_req(fw_load_req),
   .cfg_load_req(cfg_load_req), .cfg_space(cfg_space), .boot_source(boot_source),
   .link_rst_n(link_rst_n), .head_rst_n(head_rst_n), .acq_active(acq_active),
   .fan_on(fan_on), .temp_sensor(temp_sensor), .temp_mainboard(temp_mainboard),
   .temp_sensorboard(temp_sensorboard), .temp_logic(temp_logic)
);

// *** tb/devctl_flash_model.sv ***
// Behavioural model of the boot flash and workspace store beside the block.
module devctl_flash_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic fw_load_req,
   input  wire logic cfg_load_req,
   input  wire logic slow,
   output logic      fw_valid,
   output logic      fw_done,
   output logic      cfg_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] req_q;
   logic [5:0] cnt;

   // The program flash always holds a good image here.
   assign fw_valid = 1'b1;

   // Done is shown only while its own request stands; a slow store keeps startup open.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= 2'h0;
         cnt <= 6'h0;
         fw_done <= 1'b0;
         cfg_done <= 1'b0;
      end else begin
         req_q <= {fw_load_req, cfg_load_req};
         if (req_q != {fw_load_req, cfg_load_req}) begin
            cnt <= 6'h0;
            fw_done <= 1'b0;
            cfg_done <= 1'b0;
         end else if (cnt == (slow ? 6'h28 : 6'h2)) begin
            fw_done <= fw_load_req;
            cfg_done <= cfg_load_req;
         end else begin
            cnt <= cnt + 6'h1;
         end
      end
   end
endmodule

// *** tb/devctl_tb.sv ***
// Self-checking testbench of the device control block.
`include "devctl_consts.svh"
module devctl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic        w;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic        e;
   } row_s;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, slow;
   logic        fw_valid, fw_done, cfg_done, fw_load_req, cfg_load_req, fw_prev;
   logic        link_rst_n, head_rst_n, settings_load, acq_active, fan_on;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  boot_source, cfg_space;
   logic [7:0]  t0, t1, t2, t3;
   int          num_errors = 0, n_compared = 0, n_ld = 0, n_link = 0, n_fw = 0, k;
   // A write row with a nonzero expected value skips the error check.
   row_s rows [19] = '{
      '{1'b0, `OFS_COOL_MODE, 32'h0, 32'h2, 1'b0},
      '{1'b0, `OFS_SETPOINT, 32'h0, 32'h32, 1'b0},
      '{1'b0, `OFS_NAMING_VER, 32'h0, 32'h0002_0300, 1'b0},
      '{1'b0, `OFS_SCAN_TYPE, 32'h0, 32'h0, 1'b0},
      '{1'b1, `OFS_TEMP_SEL, 32'h0, 32'h0, 1'b0}, '{1'b0, `OFS_TEMP_READ, 32'h0, 32'h1E, 1'b0},
      '{1'b1, `OFS_TEMP_SEL, 32'h1, 32'h0, 1'b0}, '{1'b0, `OFS_TEMP_READ, 32'h0, 32'h1F, 1'b0},
      '{1'b1, `OFS_TEMP_SEL, 32'h2, 32'h0, 1'b0}, '{1'b0, `OFS_TEMP_READ, 32'h0, 32'h20, 1'b0},
      '{1'b1, `OFS_TEMP_SEL, 32'h3, 32'h0, 1'b0}, '{1'b0, `OFS_TEMP_READ, 32'h0, 32'h21, 1'b0},
      '{1'b1, `OFS_COOL_MODE, 32'h3, 32'h0, 1'b1},
      '{1'b1, `OFS_VENDOR, 32'hFF, 32'h1, 1'b0}, '{1'b0, `OFS_VENDOR, 32'h0, 32'h1, 1'b0},
      '{1'b1, `OFS_USER_LABEL, 32'hA5A5_0001, 32'h0, 1'b0},
      '{1'b0, `OFS_USER_LABEL, 32'h0, 32'hA5A5_0001, 1'b0},
      '{1'b0, 12'h0FC, 32'h0, 32'h0, 1'b1}, '{1'b0, 12'h002, 32'h0, 32'h0, 1'b1}};

   devctl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .fw_valid(fw_valid), .fw_done(fw_done), .boot_source(boot_source),
      .cfg_done(cfg_done), .fw_load_req(fw_load_req), .cfg_load_req(cfg_load_req),
      .cfg_space(cfg_space), .link_rst_n(link_rst_n), .head_rst_n(head_rst_n),
      .settings_load(settings_load), .acq_active(acq_active), .fan_on(fan_on),
      .temp_sensor(t0), .temp_mainboard(t1), .temp_sensorboard(t2), .temp_logic(t3));
   devctl_flash_model u_flash (.pclk(pclk), .presetn(presetn), .fw_load_req(fw_load_req),
      .cfg_load_req(cfg_load_req), .slow(slow), .fw_valid(fw_valid), .fw_done(fw_done),
      .cfg_done(cfg_done));

   // Clock, and a watchdog well past the expected run length.
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      #200us;
      num_errors++;
      summarize();
   end
   // Pulse counters; load and link pulses stand one cycle, so every edge is looked at; firmware requests count on their rise.
   always @(posedge pclk) begin
      if (presetn) begin
         n_ld <= n_ld + settings_load;
         n_link <= n_link + !link_rst_n;
         n_fw <= n_fw + (fw_load_req && !fw_prev);
      end
      fw_prev <= fw_load_req;
   end

   task automatic chk32(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic chkb(input string nm, input logic x, input logic g);
      chk32(nm, {31'h0, x}, {31'h0, g});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer; the request holds until pready is seen at a rising edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 64) num_errors++;
   endtask
   task automatic wait_ready();
      int n = 0;
      do begin
         apb(1'b0, `OFS_STATUS, 32'h0, rd, er);
         n++;
      end while (rd[0] !== 1'b1 && n < 100);
      chkb("ready", 1'b1, rd[0]);
   endtask
   task automatic heat(input logic [7:0] t);
      t3 <= t;
      tick(3);
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ****************************************
   // Main sequence.
   // ****************************************
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {boot_source, slow, t0, t1, t2, t3} = {3'h3, 1'b1, 32'h1E1F_2021};
      tick(10);
      presetn <= 1'b1;
      apb(1'b1, `OFS_SETPOINT, 32'h40, rd, er);
      chkb("early_write", 1'b1, er);
      wait_ready();
      chk32("space", 32'h3, {29'h0, cfg_space});
      chk32("status_space", 32'h3, {29'h0, rd[10:8]});
      slow <= 1'b0;
      $display("test startup done");
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
         if (!rows[i].w) chk32("rdata", rows[i].x, rd);
         if (!rows[i].w || rows[i].x == 32'h0) chkb("err", rows[i].e, er);
      end
      $display("test table done");
      apb(1'b1, `OFS_CONTROL, 32'h4, rd, er);
      tick(2);
      chkb("acq_on", 1'b1, acq_active);
      apb(1'b1, `OFS_LOCKED_PARAM, 32'h77, rd, er);
      chkb("locked_err", 1'b1, er);
      apb(1'b0, `OFS_STATUS, 32'h0, rd, er);
      chkb("refused_bit", 1'b1, rd[5]);
      apb(1'b1, `OFS_CONTROL, 32'h8, rd, er);
      apb(1'b1, `OFS_LOCKED_PARAM, 32'h55, rd, er);
      chkb("locked_ok", 1'b0, er);
      apb(1'b0, `OFS_LOCKED_PARAM, 32'h0, rd, er);
      chk32("locked_val", 32'h55, rd);
      $display("test lock done");
      heat(8'h32);
      chkb("auto_on", 1'b1, fan_on);
      heat(8'h2F);
      chkb("auto_hold", 1'b1, fan_on);
      heat(8'h2E);
      chkb("auto_off", 1'b0, fan_on);
      apb(1'b1, `OFS_COOL_MODE, 32'h0, rd, er);
      heat(8'h51);
      chkb("over_on", 1'b1, fan_on);
      heat(8'h50);
      chkb("over_release", 1'b0, fan_on);
      apb(1'b1, `OFS_COOL_MODE, 32'h1, rd, er);
      tick(2);
      chkb("mode_on", 1'b1, fan_on);
      apb(1'b1, `OFS_COOL_MODE, 32'h2, rd, er);
      heat(8'h21);
      $display("test fan done");
      apb(1'b1, `OFS_CONTROL, 32'h4, rd, er);
      apb(1'b1, `OFS_CONTROL, 32'h2, rd, er);
      tick(2);
      chkb("head_low", 1'b0, head_rst_n);
      chkb("head_acq", 1'b0, acq_active);
      chk32("head_link", 32'h0, n_link);
      tick(10);
      chkb("head_back", 1'b1, head_rst_n);
      k = n_ld;
      apb(1'b1, `OFS_CONTROL, 32'h10, rd, er);
      tick(2);
      chk32("load_pulse", 32'h1, n_ld - k);
      $display("test head reset done");
      apb(1'b1, `OFS_CONTROL, 32'h1, rd, er);
      tick(3);
      chk32("link_pulse", 32'h1, n_link);
      wait_ready();
      chk32("fw_reload", 32'h2, n_fw);
      apb(1'b0, `OFS_USER_LABEL, 32'h0, rd, er);
      chk32("label_cleared", 32'h0, rd);
      $display("test full reset done");
      summarize();
   end
endmodule
